// ---- rtl/rtsc_regs.svh ----
/*
 * Register offsets, field positions, reset values and timing counts for the
 * transfer switch controller.
 * Assumes a 20 MHz core clock and a byte-addressed Avalon-MM slave port.
 */
`ifndef RTSC_REGS_SVH
`define RTSC_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RTSC_CTRL_OFS        4'h0
`define RTSC_CMD_OFS         4'h4
`define RTSC_STATUS_OFS      4'h8

// ----------------------------------------------------------------------------
// ctrl fields
// ----------------------------------------------------------------------------
`define RTSC_CTRL_AUTO_BIT   0
`define RTSC_CTRL_REVERT_BIT 1
`define RTSC_CTRL_FAULT_BIT  2
`define RTSC_CTRL_AUTO_RST   1'b1
`define RTSC_CTRL_REVERT_RST 1'b0
`define RTSC_CTRL_FAULT_RST  1'b0

// ----------------------------------------------------------------------------
// cmd fields (write only)
// ----------------------------------------------------------------------------
`define RTSC_CMD_PRIME_BIT   0
`define RTSC_CMD_SPARE_BIT   1

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define RTSC_ST_PRIME_BIT    0
`define RTSC_ST_ROLE_BIT     1
`define RTSC_ST_PEER_BIT     2
`define RTSC_ST_BUSY_BIT     3
`define RTSC_ST_TMO_BIT      4
`define RTSC_ST_REFUSE_BIT   5
`define RTSC_ST_AUTO_BIT     6

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RTSC_CLK_HZ          20000000
`define RTSC_SWITCH_MS       50
`define RTSC_SWITCH_CYC      ((`RTSC_SWITCH_MS * `RTSC_CLK_HZ) / 1000)
`define RTSC_REVERT_MS       1000
`define RTSC_REVERT_CYC      (`RTSC_REVERT_MS * (`RTSC_CLK_HZ / 1000))
`define RTSC_TMR_W           25

`endif

// ---- rtl/rtsc_pkg.sv ----
/*
 * Types shared by the transfer switch controller.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package rtsc_pkg;

	// ------------------------------------------------------------------------
	// switch command sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		RTSC_IDLE        = 3'b001,
		RTSC_DRIVE_PRIME = 3'b010,
		RTSC_DRIVE_SPARE = 3'b100
	} rtsc_state_e;

endpackage : rtsc_pkg

`default_nettype wire

// ---- rtl/rtsc_sync.sv ----
/*
 * Two-flop synchronisers for the switch connector inputs.
 * Assumes inputs are asynchronous levels; reset value is given per bit.
 */
`default_nettype none

module rtsc_sync #(
	parameter int       WIDTH = 3,
	parameter bit [2:0] RST_VAL = 3'h0
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	// ------------------------------------------------------------------------
	// one chain per bit
	// ------------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic meta_reg;
			// first stage feeds only the second stage
			always_ff @(posedge core_clk) begin
				if (reset) begin
					meta_reg       <= RST_VAL[gi];
					sync_out[gi]   <= RST_VAL[gi];
				end else begin
					meta_reg       <= async_in[gi];
					sync_out[gi]   <= meta_reg;
				end
			end
		end
	endgenerate

endmodule : rtsc_sync

`default_nettype wire

// ---- rtl/rtsc_ctrl.sv ----
/*
 * Modulator-side controller for a one-for-one redundancy transfer switch:
 * drives the force lines and fault line of one control connector, reads back
 * switch position, peer fault and role, and takes orders over Avalon-MM.
 * Assumes connector inputs are asynchronous, a 20 MHz core_clk and a
 * synchronous active-high reset.
 */
`include "rtsc_regs.svh"
`default_nettype none

module rtsc_ctrl #(
	parameter int SWITCH_CYC = `RTSC_SWITCH_CYC,
	parameter int REVERT_CYC = `RTSC_REVERT_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	input  wire logic        switch_state,
	input  wire logic        peer_fault,
	input  wire logic        spare_role_n,
	output var  logic        prime_force_req_n,
	output var  logic        spare_force_req_n,
	output var  logic        local_fault_out
);

	// ------------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------------
	localparam logic [`RTSC_TMR_W-1:0] SW_LOAD  = `RTSC_TMR_W'(SWITCH_CYC);
	localparam logic [`RTSC_TMR_W-1:0] REV_LAST = `RTSC_TMR_W'(REVERT_CYC - 1);

	logic [2:0]               pins_sync;
	logic                     prime_online;
	logic                     peer_faulted;
	logic                     is_spare;
	rtsc_pkg::rtsc_state_e    state_reg;
	rtsc_pkg::rtsc_state_e    state_next;
	logic [`RTSC_TMR_W-1:0]   sw_tmr_reg;
	logic [`RTSC_TMR_W-1:0]   rev_tmr_reg;
	logic                     auto_en_reg;
	logic                     revert_en_reg;
	logic                     fault_reg;
	logic                     tmo_reg;
	logic                     refuse_reg;
	logic                     autosw_reg;
	logic                     acc_now;
	logic                     wr_now;
	logic                     wr_ctrl;
	logic                     wr_cmd;
	logic                     wr_status;
	logic                     cmd_prime;
	logic                     cmd_spare;
	logic                     cmd_refused;
	logic                     auto_go;
	logic                     revert_go;
	logic                     go_prime;
	logic                     go_spare;
	logic                     sw_done;
	logic                     sw_tmo;
	logic [31:0]              rd_mux;

	// ------------------------------------------------------------------------
	// connector inputs
	// ------------------------------------------------------------------------
	// role line idles high so an unplugged unit comes up as prime
	rtsc_sync #(
		.WIDTH   (3),
		.RST_VAL (3'h4)
	) u_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in ({spare_role_n, peer_fault, switch_state}),
		.sync_out (pins_sync)
	);

	assign prime_online = pins_sync[0];
	assign peer_faulted = pins_sync[1];
	assign is_spare     = ~pins_sync[2];

	// ------------------------------------------------------------------------
	// avalon slave handshake
	// ------------------------------------------------------------------------
	// one wait cycle, then the access completes on the edge waitrequest is low
	assign acc_now   = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_now    = avs_write & ~avs_waitrequest & avs_byteenable[0];
	assign wr_ctrl   = wr_now & (avs_address == `RTSC_CTRL_OFS);
	assign wr_cmd    = wr_now & (avs_address == `RTSC_CMD_OFS);
	assign wr_status = wr_now & (avs_address == `RTSC_STATUS_OFS);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read | avs_write) & avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// read data captured in the wait cycle so it stands at the completing edge
	always_comb begin
		rd_mux = 32'h0;
		unique case (avs_address)
			`RTSC_CTRL_OFS: begin
				rd_mux[`RTSC_CTRL_AUTO_BIT]   = auto_en_reg;
				rd_mux[`RTSC_CTRL_REVERT_BIT] = revert_en_reg;
				rd_mux[`RTSC_CTRL_FAULT_BIT]  = fault_reg;
			end
			`RTSC_STATUS_OFS: begin
				rd_mux[`RTSC_ST_PRIME_BIT]  = prime_online;
				rd_mux[`RTSC_ST_ROLE_BIT]   = is_spare;
				rd_mux[`RTSC_ST_PEER_BIT]   = peer_faulted;
				rd_mux[`RTSC_ST_BUSY_BIT]   = (state_reg != rtsc_pkg::RTSC_IDLE);
				rd_mux[`RTSC_ST_TMO_BIT]    = tmo_reg;
				rd_mux[`RTSC_ST_REFUSE_BIT] = refuse_reg;
				rd_mux[`RTSC_ST_AUTO_BIT]   = autosw_reg;
			end
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			avs_readdata <= 32'h0;
		end else if (avs_read & avs_waitrequest) begin
			avs_readdata <= rd_mux;
		end
	end

	// ------------------------------------------------------------------------
	// control register
	// ------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			auto_en_reg   <= `RTSC_CTRL_AUTO_RST;
			revert_en_reg <= `RTSC_CTRL_REVERT_RST;
			fault_reg     <= `RTSC_CTRL_FAULT_RST;
		end else if (wr_ctrl) begin
			auto_en_reg   <= avs_writedata[`RTSC_CTRL_AUTO_BIT];
			revert_en_reg <= avs_writedata[`RTSC_CTRL_REVERT_BIT];
			fault_reg     <= avs_writedata[`RTSC_CTRL_FAULT_BIT];
		end
	end

	// fault line to the switch, seen by the peer as its fault monitor
	always_ff @(posedge core_clk) begin
		if (reset) begin
			local_fault_out <= `RTSC_CTRL_FAULT_RST;
		end else begin
			local_fault_out <= fault_reg;
		end
	end

	// ------------------------------------------------------------------------
	// command sources
	// ------------------------------------------------------------------------
	// a faulted unit, a busy sequencer, or both bits at once refuse the order
	assign cmd_refused = wr_cmd & (avs_writedata[1:0] != 2'h0)
	                   & (fault_reg | (state_reg != rtsc_pkg::RTSC_IDLE)
	                      | (avs_writedata[1:0] == 2'h3));
	assign cmd_prime   = wr_cmd & ~cmd_refused & avs_writedata[`RTSC_CMD_PRIME_BIT];
	assign cmd_spare   = wr_cmd & ~cmd_refused & avs_writedata[`RTSC_CMD_SPARE_BIT];

	// backup watches the prime and takes over on its fault
	assign auto_go   = is_spare & auto_en_reg & peer_faulted & prime_online
	                 & ~fault_reg & ~wr_cmd;
	// revert only when enabled and the prime has been healthy long enough
	assign revert_go = is_spare & revert_en_reg & ~prime_online & ~peer_faulted
	                 & ~fault_reg & ~wr_cmd & (rev_tmr_reg == REV_LAST);

	assign go_prime = cmd_prime | revert_go;
	assign go_spare = cmd_spare | (auto_go & ~revert_go);

	// healthy-prime qualify timer for revertive mode
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rev_tmr_reg <= '0;
		end else if (~revert_en_reg | prime_online | peer_faulted) begin
			rev_tmr_reg <= '0;
		end else if (rev_tmr_reg != REV_LAST) begin
			rev_tmr_reg <= rev_tmr_reg + `RTSC_TMR_W'(1);
		end
	end

	// ------------------------------------------------------------------------
	// force sequencer
	// ------------------------------------------------------------------------
	// a force line is held until the position reads back, the switch time runs out or the fault bit is set
	assign sw_done = ((state_reg == rtsc_pkg::RTSC_DRIVE_PRIME) & prime_online)
	               | ((state_reg == rtsc_pkg::RTSC_DRIVE_SPARE) & ~prime_online);
	assign sw_tmo  = (sw_tmr_reg == '0) & ~sw_done;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			rtsc_pkg::RTSC_IDLE: begin
				if (go_prime) begin
					state_next = rtsc_pkg::RTSC_DRIVE_PRIME;
				end else if (go_spare) begin
					state_next = rtsc_pkg::RTSC_DRIVE_SPARE;
				end
			end
			rtsc_pkg::RTSC_DRIVE_PRIME, rtsc_pkg::RTSC_DRIVE_SPARE: begin
				if (sw_done | sw_tmo | fault_reg) begin
					state_next = rtsc_pkg::RTSC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= rtsc_pkg::RTSC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sw_tmr_reg <= '0;
		end else if (state_reg == rtsc_pkg::RTSC_IDLE) begin
			sw_tmr_reg <= SW_LOAD;
		end else if (sw_tmr_reg != '0) begin
			sw_tmr_reg <= sw_tmr_reg - `RTSC_TMR_W'(1);
		end
	end

	// only one force line low at a time, so the switch never sees both
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prime_force_req_n <= 1'b1;
			spare_force_req_n <= 1'b1;
		end else begin
			prime_force_req_n <= ~(state_next == rtsc_pkg::RTSC_DRIVE_PRIME);
			spare_force_req_n <= ~(state_next == rtsc_pkg::RTSC_DRIVE_SPARE);
		end
	end

	// ------------------------------------------------------------------------
	// sticky status, set wins over write-one-to-clear
	// ------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tmo_reg    <= 1'b0;
			refuse_reg <= 1'b0;
			autosw_reg <= 1'b0;
		end else begin
			tmo_reg    <= (tmo_reg & ~(wr_status & avs_writedata[`RTSC_ST_TMO_BIT]))
			            | ((state_reg != rtsc_pkg::RTSC_IDLE) & sw_tmo);
			refuse_reg <= (refuse_reg & ~(wr_status & avs_writedata[`RTSC_ST_REFUSE_BIT]))
			            | cmd_refused;
			autosw_reg <= (autosw_reg & ~(wr_status & avs_writedata[`RTSC_ST_AUTO_BIT]))
			            | ((state_reg == rtsc_pkg::RTSC_IDLE) & go_spare & ~cmd_spare);
		end
	end

endmodule : rtsc_ctrl

`default_nettype wire

// ---- testbench/rtsc_switch_model.sv ----
/* behavioural transfer switch: two control connectors, rf routing, status relay.
   assumes the controller under test sits on one connector and the bench on the other. */
`default_nettype none
module rtsc_switch_model (
	input  wire logic sel_bk,
	input  wire logic d_prime_n,
	input  wire logic d_spare_n,
	input  wire logic d_fault,
	input  wire logic o_prime_n,
	input  wire logic o_spare_n,
	input  wire logic o_fault,
	input  wire logic stuck,
	input  wire logic mod_p,
	input  wire logic mod_b,
	output wire logic state,
	output wire logic d_peer,
	output wire logic o_peer,
	output wire logic d_role_n,
	output wire logic o_role_n,
	output wire logic online,
	output wire logic offline,
	output wire logic relay_no,
	output wire logic relay_nc
);
	// ------------------------------------------------------------------
	// switch position
	// ------------------------------------------------------------------
	logic pos_prime = 1'b1; // power-up position is a free choice
	wire  logic p_req = !d_prime_n || !o_prime_n;
	wire  logic s_req = !d_spare_n || !o_spare_n;
	// stuck models a jammed switch so that the controller's timeout can be seen
	always @* begin
		if (!stuck && p_req && !s_req) pos_prime = 1'b1;
		else if (!stuck && s_req && !p_req) pos_prime = 1'b0;
	end
	// routing and indicators follow the position directly; fault lines cross over regardless of it
	assign state = pos_prime;
	assign online = pos_prime ? mod_p : mod_b;
	assign offline = pos_prime ? mod_b : mod_p;
	assign d_peer = o_fault;
	assign o_peer = d_fault;
	assign d_role_n = !sel_bk;
	assign o_role_n = sel_bk;
	assign relay_no = !pos_prime;
	assign relay_nc = pos_prime;
endmodule : rtsc_switch_model
`default_nettype wire

// ---- testbench/rtsc_ctrl_properties.sv ----
/* timing properties of the controller's bus and force lines.
   assumes binding onto rtsc_ctrl with one clock and a synchronous reset. */
`default_nettype none
module rtsc_ctrl_chk (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        switch_state,
	input wire logic        peer_fault,
	input wire logic        spare_role_n,
	input wire logic        prime_force_req_n,
	input wire logic        spare_force_req_n,
	input wire logic        local_fault_out
);
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// one wait cycle, then a single low cycle
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest did not drop after one cycle");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_force_excl: assert property (prime_force_req_n || spare_force_req_n)
		else $error("both force lines low");
	a_fault_block: assert property (local_fault_out && $past(local_fault_out)
		|-> !$fell(prime_force_req_n) && !$fell(spare_force_req_n))
		else $error("force started while faulted");
	a_fault_release: assert property (local_fault_out [*3] |-> prime_force_req_n && spare_force_req_n)
		else $error("force held while faulted");
	// the prime unit only moves the switch on a command write
	a_prime_manual: assert property (($fell(prime_force_req_n) || $fell(spare_force_req_n)) && spare_role_n
		&& $past(spare_role_n, 2) && $past(spare_role_n, 3) |-> $past(avs_write && !avs_waitrequest))
		else $error("force without command on prime unit");
	// pins are synchronised, so a few cycles of slack are allowed
	a_auto_spare: assert property ((!spare_role_n && switch_state && peer_fault && !local_fault_out) [*6]
		|-> !spare_force_req_n)
		else $error("backup did not take over on peer fault");
	a_spare_release: assert property ((!spare_force_req_n && !switch_state) [*4] |=> spare_force_req_n)
		else $error("backup force held after switch moved");
	a_prime_release: assert property ((!prime_force_req_n && switch_state) [*4] |=> prime_force_req_n)
		else $error("prime force held after switch moved");
endmodule : rtsc_ctrl_chk
bind rtsc_ctrl rtsc_ctrl_chk u_chk (.core_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_readdata, .avs_waitrequest, .switch_state, .peer_fault, .spare_role_n,
	.prime_force_req_n, .spare_force_req_n, .local_fault_out);
`default_nettype wire

// ---- testbench/test_redundancy_transfer_switch_control.sv ----
/* self-checking bench: controller on one switch connector, bench on the other.
   assumes the switch model and the bound checker are compiled beside it. */
`default_nettype none
module test_redundancy_transfer_switch_control;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------------
	// signals, rows and tasks
	// ------------------------------------------------------------------
	typedef struct {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} rtsc_row_s;
	logic        core_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic        avs_waitrequest, sw, peer, role_n, pfn, sfn, lfo, online, offline, rno, rnc, o_peer;
	logic        sel_bk = 1'b0, o_prime_n = 1'b1, o_spare_n = 1'b1, o_fault = 1'b0, stuck = 1'b0;
	int          n_mismatch = 0, total_checks = 0;
	// reset values, access kinds and an unmapped place
	rtsc_row_s rows [9] = '{'{1'b0, 4'h0, 32'h0, 32'h1}, '{1'b0, 4'h8, 32'h0, 32'h1},
		'{1'b1, 4'h0, 32'h2, 32'h0}, '{1'b0, 4'h0, 32'h0, 32'h2}, '{1'b1, 4'h0, 32'h1, 32'h0},
		'{1'b0, 4'h0, 32'h0, 32'h1}, '{1'b0, 4'h4, 32'h0, 32'h0}, '{1'b1, 4'hc, 32'hffffffff, 32'h0},
		'{1'b0, 4'hc, 32'h0, 32'h0}};
	always #25 core_clk = ~core_clk;
	rtsc_ctrl #(.SWITCH_CYC(20), .REVERT_CYC(10)) dut (.core_clk(core_clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.switch_state(sw), .peer_fault(peer), .spare_role_n(role_n), .prime_force_req_n(pfn),
		.spare_force_req_n(sfn), .local_fault_out(lfo));
	rtsc_switch_model u_sw (.sel_bk(sel_bk), .d_prime_n(pfn), .d_spare_n(sfn), .d_fault(lfo),
		.o_prime_n(o_prime_n), .o_spare_n(o_spare_n), .o_fault(o_fault), .stuck(stuck), .mod_p(1'b1),
		.mod_b(1'b0), .state(sw), .d_peer(peer), .o_peer(o_peer), .d_role_n(role_n), .o_role_n(),
		.online(online), .offline(offline), .relay_no(rno), .relay_nc(rnc));
	task wrap_up;
		if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task chk_word(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk_word
	task chk_bit(input logic g, input logic e);
		chk_word({31'h0, g}, {31'h0, e});
	endtask : chk_bit
	// request held until waitrequest is sampled low, one idle edge after
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			chk_bit(avs_waitrequest, 1'b0);
			wrap_up;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : bus
	task wait_sw(input logic e);
		for (int i = 0; i < 60 && sw !== e; i++)
			@(posedge core_clk);
		chk_bit(sw, e);
		if (sw !== e) wrap_up;
	endtask : wait_sw
	task wait_idle;
		for (int i = 0; i < 60 && !(pfn === 1'b1 && sfn === 1'b1); i++)
			@(posedge core_clk);
		chk_bit(pfn & sfn, 1'b1);
		if (pfn !== 1'b1 || sfn !== 1'b1) wrap_up;
	endtask : wait_idle
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		foreach (rows[i]) begin
			bus(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk_word(q, rows[i].e);
		end
		bus(1'b1, 4'h4, 32'h2);
		wait_sw(1'b0);
		chk_bit(rno, 1'b1);
		chk_bit(rnc, 1'b0);
		chk_bit(online, 1'b0);
		chk_bit(offline, 1'b1);
		wait_idle();
		repeat (20) @(posedge core_clk);
		chk_bit(sw, 1'b0);
		bus(1'b1, 4'h4, 32'h1);
		wait_sw(1'b1);
		wait_idle();
		// far controller forces, then both lines at once
		o_spare_n <= 1'b0;
		wait_sw(1'b0);
		o_prime_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk_bit(sw, 1'b0);
		o_spare_n <= 1'b1;
		wait_sw(1'b1);
		o_prime_n <= 1'b1;
		// faulted unit and double command are refused
		bus(1'b1, 4'h0, 32'h5);
		// fault line is registered one edge after the write lands
		@(posedge core_clk);
		chk_bit(o_peer, 1'b1);
		bus(1'b1, 4'h4, 32'h2);
		bus(1'b0, 4'h8, 32'h0);
		chk_word(q, 32'h21);
		bus(1'b1, 4'h0, 32'h1);
		bus(1'b1, 4'h8, 32'h20);
		bus(1'b1, 4'h4, 32'h3);
		bus(1'b0, 4'h8, 32'h0);
		chk_word(q, 32'h21);
		bus(1'b1, 4'h8, 32'h20);
		// jammed switch runs the sequencer into its timeout
		stuck <= 1'b1;
		bus(1'b1, 4'h4, 32'h2);
		wait_idle();
		bus(1'b0, 4'h8, 32'h0);
		chk_word(q, 32'h11);
		bus(1'b1, 4'h8, 32'h10);
		stuck <= 1'b0;
		// backup role: take over on peer fault, no return until revert is enabled
		sel_bk <= 1'b1;
		o_fault <= 1'b1;
		wait_sw(1'b0);
		wait_idle();
		bus(1'b0, 4'h8, 32'h0);
		chk_word(q, 32'h46);
		o_fault <= 1'b0;
		repeat (30) @(posedge core_clk);
		chk_bit(sw, 1'b0);
		bus(1'b1, 4'h0, 32'h3);
		wait_sw(1'b1);
		wait_idle();
		// reset in mid-run, fault line raised first so its clear can be seen
		bus(1'b1, 4'h0, 32'h5);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk_bit(avs_waitrequest, 1'b1);
		chk_word(avs_readdata, 32'h0);
		chk_bit(pfn & sfn, 1'b1);
		chk_bit(lfo, 1'b0);
		reset <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, 4'h0, 32'h0);
		chk_word(q, 32'h1);
		wrap_up;
	end
endmodule : test_redundancy_transfer_switch_control
`default_nettype wire
